// ==== four_channel_dma_transaction_engine.sv ====
// four channel transfer engine sharing the data bus with the core
// Functional notes
// - four channels run independently and in parallel
// - each channel has its own settings
// - block length 1 byte to 64KB
// - repeat count 1-255, zero means unlimited
// - transaction of blocks, up to 16MB
// - bursts of 1, 2, 4 or 8 bytes
// - bus kept until burst completes
// - core wins the bus between bursts
// - static, incrementing or decrementing addresses
// - address reload per burst, block or transaction
// - start by software, peripheral or event
// - per-channel completion and error interrupts
// - paired channels hand over alternately
// - nonvolatile storage readable as a source
// - moved data optionally fed to checksum
// - trigger moves whole transaction or one burst
// - one trigger held pending, extras dropped
`timescale 1ns/10ps
module four_channel_dma_transaction_engine (
   input wire logic clock,
   input wire logic rst,
   input wire dma_pkg::ch_cfg_t [dma_pkg::NUM_CH-1:0] cfg,
   input wire logic [dma_pkg::NUM_CH-1:0] arm,
   input wire logic [dma_pkg::NUM_CH-1:0] abort,
   input wire logic [dma_pkg::NUM_CH-1:0] trig_sw,
   input wire logic [dma_pkg::NUM_CH-1:0] periph_req,
   input wire logic [dma_pkg::NUM_CH-1:0] evt,
   input wire logic [1:0] pair_en,
   input wire logic cpu_req,
   input wire logic nvm_off,
   input wire logic [7:0] mem_rdata,
   output logic bus_own_r,
   output logic [dma_pkg::ADDR_W-1:0] mem_addr_r,
   output logic mem_rd_r,
   output logic mem_wr_r,
   output logic [7:0] mem_wdata_r,
   output logic crc_valid_r,
   output logic [7:0] crc_data_r,
   output logic [dma_pkg::NUM_CH-1:0] done_irq_r,
   output logic [dma_pkg::NUM_CH-1:0] err_irq_r,
   output logic [dma_pkg::NUM_CH-1:0] busy
);
   import dma_pkg::*;

   eng_state_t st_r, st_nxt;
   logic [1:0] ch_r, ch_nxt, rr_r, rr_nxt, sel;
   logic [2:0] cnt_r, cnt_nxt;
   logic own_nxt, rd_nxt, wr_nxt, crc_v_nxt, found, burst_end;
   logic [ADDR_W-1:0] addr_nxt;
   logic [7:0] wdata_nxt, crc_d_nxt;
   logic [3:0] blen;
   logic [16:0] left_sel;
   logic [NUM_CH-1:0] req, done, err, take, step, fault, arm_int;
   logic [ADDR_W-1:0] src [NUM_CH];
   logic [ADDR_W-1:0] dst [NUM_CH];
   logic [16:0] left [NUM_CH];

   ////////////////////////////////////////////////////////////////////////////////
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      // the partner is armed from its own settings once this one finishes
      assign arm_int[i] = arm[i] || (pair_en[i/2] && done[i^1] && !busy[i]);
      dma_channel u_ch (
         .clock(clock),
         .rst(rst),
         .cfg(cfg[i]),
         .arm(arm_int[i]),
         .abort(abort[i]),
         .trig_sw(trig_sw[i]),
         .trig_periph(periph_req[i]),
         .trig_evt(evt[i]),
         .take(take[i]),
         .step(step[i]),
         .burst_end(burst_end),
         .fault(fault[i]),
         .req(req[i]),
         .busy_r(busy[i]),
         .done_r(done[i]),
         .err_r(err[i]),
         .src_r(src[i]),
         .dst_r(dst[i]),
         .left_r(left[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   // round robin pick: the channel that moved last goes to the back
   always_comb begin
      logic [1:0] idx;
      idx = 2'h0;
      sel = 2'h0;
      found = 1'b0;
      for (int k = 0; k < NUM_CH; k++) begin
         idx = rr_r + 2'(k + 1);
         if (!found && req[idx]) begin
            sel = idx;
            found = 1'b1;
         end
      end
      left_sel = left[sel];
      blen = 4'h1 << cfg[sel].burst_sel;
      if (left_sel < 17'(blen)) begin
         blen = left_sel[3:0];
      end
   end

   always_comb begin
      st_nxt = st_r;
      ch_nxt = ch_r;
      rr_nxt = rr_r;
      cnt_nxt = cnt_r;
      own_nxt = bus_own_r;
      rd_nxt = 1'b0;
      wr_nxt = 1'b0;
      crc_v_nxt = 1'b0;
      addr_nxt = mem_addr_r;
      wdata_nxt = mem_wdata_r;
      crc_d_nxt = crc_data_r;
      take = '0;
      step = '0;
      fault = '0;
      burst_end = 1'b0;
      case (st_r)
         ST_IDLE: begin
            // a burst only starts on a cycle the core leaves the bus alone
            if (found && !cpu_req) begin
               take[sel] = 1'b1;
               ch_nxt = sel;
               cnt_nxt = 3'(blen - 4'h1);
               if (nvm_off && in_nvm(src[sel])) begin
                  fault[sel] = 1'b1;
               end else begin
                  st_nxt = ST_RD;
                  own_nxt = 1'b1;
                  rd_nxt = 1'b1;
                  addr_nxt = src[sel];
               end
            end
         end
         ST_RD: begin
            st_nxt = ST_CAP;
         end
         ST_CAP: begin
            if (!busy[ch_r]) begin
               st_nxt = ST_IDLE;
               own_nxt = 1'b0;
            end else if (in_nvm(dst[ch_r])) begin
               fault[ch_r] = 1'b1;
               st_nxt = ST_IDLE;
               own_nxt = 1'b0;
            end else begin
               st_nxt = ST_WR;
               wr_nxt = 1'b1;
               addr_nxt = dst[ch_r];
               wdata_nxt = mem_rdata;
               crc_v_nxt = cfg[ch_r].crc_en;
               crc_d_nxt = mem_rdata;
               step[ch_r] = 1'b1;
               burst_end = (cnt_r == 3'h0);
            end
         end
         ST_WR: begin
            // no look at cpu_req here: the bus stays ours to the burst's end
            if (cnt_r != 3'h0 && busy[ch_r]) begin
               cnt_nxt = cnt_r - 3'h1;
               st_nxt = ST_RD;
               rd_nxt = 1'b1;
               addr_nxt = src[ch_r];
            end else begin
               st_nxt = ST_IDLE;
               own_nxt = 1'b0;
               rr_nxt = ch_r;
            end
         end
         default: begin
            st_nxt = ST_IDLE;
            own_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_r <= ST_IDLE;
         ch_r <= 2'h0;
         rr_r <= 2'h3;
         cnt_r <= 3'h0;
         bus_own_r <= 1'b0;
         mem_addr_r <= '0;
         mem_rd_r <= 1'b0;
         mem_wr_r <= 1'b0;
         mem_wdata_r <= 8'h00;
         crc_valid_r <= 1'b0;
         crc_data_r <= 8'h00;
         done_irq_r <= '0;
         err_irq_r <= '0;
      end else begin
         st_r <= st_nxt;
         ch_r <= ch_nxt;
         rr_r <= rr_nxt;
         cnt_r <= cnt_nxt;
         bus_own_r <= own_nxt;
         mem_addr_r <= addr_nxt;
         mem_rd_r <= rd_nxt;
         mem_wr_r <= wr_nxt;
         mem_wdata_r <= wdata_nxt;
         crc_valid_r <= crc_v_nxt;
         crc_data_r <= crc_d_nxt;
         for (int i = 0; i < NUM_CH; i++) begin
            done_irq_r[i] <= done[i] && cfg[i].done_ie;
            err_irq_r[i] <= err[i] && cfg[i].err_ie;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   property p_core_first;
      @(posedge clock) disable iff (rst)
      $rose(bus_own_r) |-> !$past(cpu_req);
   endproperty
   a_core_first: assert property (p_core_first) else $error("burst started over core");

   sequence s_byte;
      mem_rd_r && bus_own_r ##1 !mem_rd_r && !mem_wr_r && bus_own_r;
   endsequence
   // an abort or a refused destination may drop the byte; the bus is then freed at once
   property p_burst_hold;
      @(posedge clock) disable iff (rst)
      st_r == ST_WR && cnt_r != 3'h0 && busy[ch_r]
         |=> s_byte ##1 ((mem_wr_r && bus_own_r) || (!bus_own_r && st_r == ST_IDLE));
   endproperty
   a_burst_hold: assert property (p_burst_hold) else $error("burst left the bus");

   property p_clip;
      @(posedge clock) disable iff (rst)
      st_r == ST_IDLE && st_nxt == ST_RD |=> 17'(cnt_r) < $past(left_sel);
   endproperty
   a_clip: assert property (p_clip) else $error("burst longer than block rest");

   property p_crc;
      @(posedge clock) disable iff (rst)
      crc_valid_r |-> mem_wr_r && crc_data_r == mem_wdata_r;
   endproperty
   a_crc: assert property (p_crc) else $error("checksum byte differs from write");

   property p_no_nvm_write;
      @(posedge clock) disable iff (rst)
      mem_wr_r |-> !in_nvm(mem_addr_r) && $past(mem_rd_r, 2);
   endproperty
   a_no_nvm_write: assert property (p_no_nvm_write) else $error("bad write to nvm");
endmodule // four_channel_dma_transaction_engine

// ==== dma_pkg.sv ====
// shared types and constants for the four channel transfer engine
package dma_pkg;
   localparam int NUM_CH = 4;
   localparam int ADDR_W = 16;
   // block of 65536 bytes is written as a zero block count
   localparam logic [16:0] BLK_FULL = 17'h10000;
   localparam logic [7:0] REP_ONE = 8'h01;
   // memory-mapped nonvolatile window; plain defaults
   localparam logic [ADDR_W-1:0] NVM_BASE = 16'h1000;
   localparam logic [ADDR_W-1:0] NVM_LAST = 16'h1FFF;

   typedef enum logic [1:0] {AM_STATIC = 2'h0, AM_INC = 2'h1, AM_DEC = 2'h2} addr_mode_t;
   typedef enum logic [1:0] {RL_NONE = 2'h0, RL_BURST = 2'h1, RL_BLOCK = 2'h2,
      RL_TXN = 2'h3} reload_t;
   typedef enum logic [1:0] {TS_SW = 2'h0, TS_PERIPH = 2'h1, TS_EVENT = 2'h2} trig_src_t;
   typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_RD = 2'h1, ST_CAP = 2'h2,
      ST_WR = 2'h3} eng_state_t;

   typedef struct packed {
      trig_src_t trig_sel;
      logic single_shot;
      logic repeat_en;
      logic [7:0] repeat_cnt;
      logic [15:0] blk_cnt;
      logic [1:0] burst_sel;
      addr_mode_t src_mode;
      addr_mode_t dst_mode;
      reload_t src_reload;
      reload_t dst_reload;
      logic [ADDR_W-1:0] src_addr;
      logic [ADDR_W-1:0] dst_addr;
      logic crc_en;
      logic done_ie;
      logic err_ie;
   } ch_cfg_t;

   function automatic logic in_nvm(input logic [ADDR_W-1:0] a);
      in_nvm = (a >= NVM_BASE) && (a <= NVM_LAST);
   endfunction
endpackage

// ==== dma_channel.sv ====
// one transfer channel: triggers, counters, address generation
`timescale 1ns/10ps
module dma_channel (
   input wire logic clock,
   input wire logic rst,
   input wire dma_pkg::ch_cfg_t cfg,
   input wire logic arm,
   input wire logic abort,
   input wire logic trig_sw,
   input wire logic trig_periph,
   input wire logic trig_evt,
   input wire logic take,
   input wire logic step,
   input wire logic burst_end,
   input wire logic fault,
   output logic req,
   output logic busy_r,
   output logic done_r,
   output logic err_r,
   output logic [dma_pkg::ADDR_W-1:0] src_r,
   output logic [dma_pkg::ADDR_W-1:0] dst_r,
   output logic [16:0] left_r
);
   import dma_pkg::*;

   logic run_r, run_nxt, pend_r, pend_nxt, busy_nxt, done_nxt, err_nxt;
   logic [ADDR_W-1:0] src_nxt, dst_nxt, org_src_r, org_src_nxt, org_dst_r, org_dst_nxt;
   logic [16:0] left_nxt;
   logic [7:0] rep_r, rep_nxt;
   logic trig, blk_end, txn_end, inf;

   function automatic logic [ADDR_W-1:0] adv(input logic [ADDR_W-1:0] a, input addr_mode_t m);
      case (m)
         AM_INC: adv = a + 1'b1;
         AM_DEC: adv = a - 1'b1;
         default: adv = a;
      endcase
   endfunction

   function automatic logic hit(input reload_t r, input logic b, input logic k, input logic t);
      hit = (r == RL_BURST && b) || (r == RL_BLOCK && k) || (r == RL_TXN && t);
   endfunction

   assign req = busy_r && (run_r || pend_r);
   assign inf = cfg.repeat_en && (cfg.repeat_cnt == 8'h00);

   always_comb begin
      case (cfg.trig_sel)
         TS_SW: trig = trig_sw;
         TS_PERIPH: trig = trig_periph;
         TS_EVENT: trig = trig_evt;
         default: trig = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      run_nxt = run_r;
      pend_nxt = pend_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      err_nxt = 1'b0;
      src_nxt = src_r;
      dst_nxt = dst_r;
      org_src_nxt = org_src_r;
      org_dst_nxt = org_dst_r;
      left_nxt = left_r;
      rep_nxt = rep_r;
      blk_end = step && (left_r == 17'h00001);
      txn_end = blk_end && !inf && (rep_r == REP_ONE);
      if (take && !run_r) begin
         pend_nxt = 1'b0;
         run_nxt = !cfg.single_shot;
      end
      // a new trigger on a busy channel is kept if the slot is free or freed this cycle; else dropped
      if (trig && busy_r && (!pend_r || (take && !run_r))) begin
         pend_nxt = 1'b1;
      end
      if (step) begin
         left_nxt = left_r - 17'h00001;
         src_nxt = hit(cfg.src_reload, burst_end, blk_end, txn_end) ? org_src_r
            : adv(src_r, cfg.src_mode);
         dst_nxt = hit(cfg.dst_reload, burst_end, blk_end, txn_end) ? org_dst_r
            : adv(dst_r, cfg.dst_mode);
      end
      if (blk_end) begin
         left_nxt = (cfg.blk_cnt == 16'h0000) ? BLK_FULL : {1'b0, cfg.blk_cnt};
         if (txn_end) begin
            busy_nxt = 1'b0;
            run_nxt = 1'b0;
            pend_nxt = 1'b0;
            done_nxt = 1'b1;
         end else begin
            if (!inf) begin
               rep_nxt = rep_r - 8'h01;
            end
            done_nxt = inf;
         end
      end
      if (arm) begin
         busy_nxt = 1'b1;
         run_nxt = 1'b0;
         pend_nxt = 1'b0;
         src_nxt = cfg.src_addr;
         dst_nxt = cfg.dst_addr;
         org_src_nxt = cfg.src_addr;
         org_dst_nxt = cfg.dst_addr;
         left_nxt = (cfg.blk_cnt == 16'h0000) ? BLK_FULL : {1'b0, cfg.blk_cnt};
         rep_nxt = cfg.repeat_en ? cfg.repeat_cnt : REP_ONE;
      end
      if (fault || (abort && busy_r)) begin
         busy_nxt = 1'b0;
         run_nxt = 1'b0;
         pend_nxt = 1'b0;
         err_nxt = fault || run_r;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         run_r <= 1'b0;
         pend_r <= 1'b0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         err_r <= 1'b0;
         src_r <= '0;
         dst_r <= '0;
         org_src_r <= '0;
         org_dst_r <= '0;
         left_r <= BLK_FULL;
         rep_r <= REP_ONE;
      end else begin
         run_r <= run_nxt;
         pend_r <= pend_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
         err_r <= err_nxt;
         src_r <= src_nxt;
         dst_r <= dst_nxt;
         org_src_r <= org_src_nxt;
         org_dst_r <= org_dst_nxt;
         left_r <= left_nxt;
         rep_r <= rep_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   property p_full_block;
      @(posedge clock) disable iff (rst)
      arm && !fault && cfg.blk_cnt == 16'h0000 |=> left_r == 17'h10000;
   endproperty
   a_full_block: assert property (p_full_block) else $error("zero count is not 64K");

   property p_pend_keep;
      @(posedge clock) disable iff (rst)
      pend_r && !take && !fault && !abort && !arm && !txn_end |=> pend_r;
   endproperty
   a_pend_keep: assert property (p_pend_keep) else $error("pending trigger lost");

   property p_src_inc;
      @(posedge clock) disable iff (rst)
      step && !arm && cfg.src_mode == AM_INC && cfg.src_reload == RL_NONE
         |=> src_r == $past(src_r) + 1'b1;
   endproperty
   a_src_inc: assert property (p_src_inc) else $error("source did not increment");
endmodule // dma_channel

// ==== dma_mem_model.sv ====
// memory and core model on the far side of the engine's data bus
`timescale 1ns/10ps
module dma_mem_model (
   input wire logic clock,
   input wire logic core_access,
   input wire logic bus_own_r,
   input wire logic [dma_pkg::ADDR_W-1:0] mem_addr_r,
   input wire logic mem_rd_r,
   input wire logic mem_wr_r,
   input wire logic [7:0] mem_wdata_r,
   output logic cpu_req,
   output logic [7:0] mem_rdata,
   output int n_rd,
   output int n_wr,
   output int n_clash
);
   logic [7:0] mem [0:65535];
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'(i) ^ 8'h5A;
      end
      mem_rdata = 8'h00;
      n_rd = 0;
      n_wr = 0;
      n_clash = 0;
   end
   // the core asks for the bus on each data access it makes
   assign cpu_req = core_access;
   always @(posedge clock) begin
      // no read answered: show the inverse so stale data cannot pass
      mem_rdata <= mem_rd_r ? mem[mem_addr_r] : ~mem_rdata;
      if (mem_rd_r) n_rd <= n_rd + 1;
      if (mem_wr_r) begin
         mem[mem_addr_r] <= mem_wdata_r;
         n_wr <= n_wr + 1;
      end
      // an access without ownership would collide with the core
      if ((mem_rd_r || mem_wr_r) && !bus_own_r) n_clash <= n_clash + 1;
   end
endmodule // dma_mem_model

// ==== tb_top.sv ====
// self-checking bench for the four channel transfer engine
`timescale 1ns/10ps
module tb_top;
   import dma_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   ch_cfg_t [NUM_CH-1:0] cfg = '0;
   logic [NUM_CH-1:0] arm = '0, abort = '0, trig_sw = '0, periph_req = '0, evt = '0;
   logic [1:0] pair_en = 2'h0;
   logic nvm_off = 1'b0, core_access = 1'b0;
   logic cpu_req, bus_own_r, mem_rd_r, mem_wr_r, crc_valid_r;
   logic [7:0] mem_rdata, mem_wdata_r, crc_data_r;
   logic [ADDR_W-1:0] mem_addr_r;
   logic [NUM_CH-1:0] done_irq_r, err_irq_r, busy;
   int n_rd, n_wr, n_clash, n_crc = 0, n_errors = 0, tests_run = 0, cycles = 0;
   int n_done [NUM_CH] = '{default: 0};
   int n_err [NUM_CH] = '{default: 0};
   int w0, d0, e0;
   logic [7:0] crc_last = 8'h00;
   ch_cfg_t t;
   always #12.5 clock = ~clock;
   four_channel_dma_transaction_engine u_four_channel_dma_transaction_engine (
      .clock(clock), .rst(rst), .cfg(cfg), .arm(arm), .abort(abort), .trig_sw(trig_sw),
      .periph_req(periph_req), .evt(evt), .pair_en(pair_en), .cpu_req(cpu_req),
      .nvm_off(nvm_off), .mem_rdata(mem_rdata), .bus_own_r(bus_own_r),
      .mem_addr_r(mem_addr_r), .mem_rd_r(mem_rd_r), .mem_wr_r(mem_wr_r),
      .mem_wdata_r(mem_wdata_r), .crc_valid_r(crc_valid_r), .crc_data_r(crc_data_r),
      .done_irq_r(done_irq_r), .err_irq_r(err_irq_r), .busy(busy));
   dma_mem_model u_dma_mem_model (
      .clock(clock), .core_access(core_access), .bus_own_r(bus_own_r),
      .mem_addr_r(mem_addr_r), .mem_rd_r(mem_rd_r), .mem_wr_r(mem_wr_r),
      .mem_wdata_r(mem_wdata_r), .cpu_req(cpu_req), .mem_rdata(mem_rdata),
      .n_rd(n_rd), .n_wr(n_wr), .n_clash(n_clash));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (crc_valid_r) n_crc <= n_crc + 1;
      if (crc_valid_r) crc_last <= crc_data_r;
      for (int i = 0; i < NUM_CH; i++) begin
         if (done_irq_r[i]) n_done[i] <= n_done[i] + 1;
         if (err_irq_r[i]) n_err[i] <= n_err[i] + 1;
      end
      if (cycles == 40000) begin
         n_errors++;
         close_out();
      end
   end
   function automatic logic [7:0] pat(input int a);
      pat = 8'(a) ^ 8'h5A;
   endfunction
   function automatic ch_cfg_t mk(input logic [15:0] blk, input logic [1:0] bs,
         input logic [15:0] sa, input logic [15:0] da);
      mk = '0;
      mk.blk_cnt = blk;
      mk.burst_sel = bs;
      mk.src_addr = sa;
      mk.dst_addr = da;
      mk.src_mode = AM_INC;
      mk.dst_mode = AM_INC;
      mk.done_ie = 1'b1;
      mk.err_ie = 1'b1;
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic start(input int c, input ch_cfg_t k);
      cfg[c] <= k;
      arm[c] <= 1'b1;
      @(posedge clock);
      arm[c] <= 1'b0;
      @(posedge clock);
      w0 = n_wr;
      d0 = n_done[c];
      e0 = n_err[c];
   endtask
   task automatic fire(input int c, input trig_src_t s);
      if (s == TS_PERIPH) periph_req[c] <= 1'b1;
      else if (s == TS_EVENT) evt[c] <= 1'b1;
      else trig_sw[c] <= 1'b1;
      @(posedge clock);
      periph_req[c] <= 1'b0;
      evt[c] <= 1'b0;
      trig_sw[c] <= 1'b0;
      @(posedge clock);
   endtask
   // busy is bounded; the extra edges let the interrupt pulse land
   task automatic wait_idle(input int c);
      int k = 0;
      while (busy[c] !== 1'b0 && k < 3000) begin
         @(posedge clock);
         k++;
      end
      check(busy[c], 1'b0);
      repeat (3) @(posedge clock);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      start(0, mk(16'h0003, 2'h1, 16'h0100, 16'h0200));
      fire(0, TS_SW);
      wait_idle(0);
      check(n_wr - w0, 3);
      for (int i = 0; i < 3; i++) check(u_dma_mem_model.mem[16'h0200 + i], pat(16'h0100 + i));
      check(n_done[0] - d0, 1);
      check(n_crc, 0);
      $display("test block done");
      t = mk(16'h0002, 2'h0, 16'h0300, 16'h0400);
      t.src_mode = AM_STATIC;
      t.repeat_en = 1'b1;
      t.repeat_cnt = 8'h02;
      t.crc_en = 1'b1;
      start(1, t);
      fire(1, TS_SW);
      wait_idle(1);
      check(n_wr - w0, 4);
      check(n_crc, 4);
      check(crc_last, pat(16'h0300));
      check(n_done[1] - d0, 1);
      for (int i = 0; i < 4; i++) check(u_dma_mem_model.mem[16'h0400 + i], pat(16'h0300));
      $display("test repeat done");
      for (int s = 0; s < 3; s++) begin
         t = mk(16'h0001, 2'h0, 16'h0310, 16'h0500 + 16'(s));
         t.trig_sel = trig_src_t'(s);
         start(2, t);
         fire(2, trig_src_t'(s));
         wait_idle(2);
         check(n_wr - w0, 1);
      end
      $display("test triggers done");
      t = mk(16'h0004, 2'h1, 16'h0600, 16'h0713);
      t.src_reload = RL_BURST;
      t.dst_mode = AM_DEC;
      start(3, t);
      fire(3, TS_SW);
      wait_idle(3);
      for (int i = 0; i < 4; i++) check(u_dma_mem_model.mem[16'h0713 - i], pat(16'h0600 + i % 2));
      $display("test reload done");
      t = mk(16'h0004, 2'h0, 16'h0320, 16'h0800);
      t.single_shot = 1'b1;
      start(0, t);
      trig_sw[0] <= 1'b1;
      repeat (3) @(posedge clock);
      trig_sw[0] <= 1'b0;
      repeat (40) @(posedge clock);
      check(n_wr - w0, 2);
      check(busy[0], 1'b1);
      fire(0, TS_SW);
      repeat (20) @(posedge clock);
      fire(0, TS_SW);
      wait_idle(0);
      check(n_wr - w0, 4);
      $display("test pending done");
      start(1, mk(16'h0010, 2'h3, 16'h0900, 16'h0A00));
      fire(1, TS_SW);
      for (int k = 0; k < 20 && bus_own_r !== 1'b1; k++) @(posedge clock);
      core_access <= 1'b1;
      repeat (60) @(posedge clock);
      check(n_wr - w0, 8);
      check(busy[1], 1'b1);
      core_access <= 1'b0;
      wait_idle(1);
      check(n_wr - w0, 16);
      check(n_clash, 0);
      check(n_rd, n_wr);
      $display("test arbiter done");
      start(2, mk(16'h0003, 2'h0, 16'h0B10, 16'h0B00));
      start(3, mk(16'h0003, 2'h2, 16'h0C10, 16'h0C80));
      w0 = n_wr;
      trig_sw <= 4'hC;
      @(posedge clock);
      trig_sw <= 4'h0;
      wait_idle(2);
      wait_idle(3);
      check(n_wr - w0, 6);
      check(u_dma_mem_model.mem[16'h0B02], pat(16'h0B12));
      check(u_dma_mem_model.mem[16'h0C82], pat(16'h0C12));
      $display("test parallel done");
      nvm_off <= 1'b1;
      start(0, mk(16'h0001, 2'h0, NVM_BASE, 16'h0D00));
      fire(0, TS_SW);
      wait_idle(0);
      check(n_err[0] - e0, 1);
      check(n_wr - w0, 0);
      nvm_off <= 1'b0;
      start(0, mk(16'h0001, 2'h0, 16'h0330, NVM_LAST));
      fire(0, TS_SW);
      wait_idle(0);
      check(n_err[0] - e0, 1);
      check(n_wr - w0, 0);
      start(0, mk(16'h0001, 2'h0, NVM_BASE, 16'h0D00));
      fire(0, TS_SW);
      wait_idle(0);
      check(u_dma_mem_model.mem[16'h0D00], pat(NVM_BASE));
      $display("test storage done");
      pair_en <= 2'h1;
      cfg[1] <= mk(16'h0002, 2'h0, 16'h0340, 16'h0E00);
      start(0, mk(16'h0002, 2'h0, 16'h0350, 16'h0E10));
      fire(0, TS_SW);
      for (int k = 0; k < 50 && busy[1] !== 1'b1; k++) @(posedge clock);
      check(busy[1], 1'b1);
      fire(1, TS_SW);
      wait_idle(1);
      check(u_dma_mem_model.mem[16'h0E01], pat(16'h0341));
      check(busy[0], 1'b1);
      pair_en <= 2'h0;
      abort[0] <= 1'b1;
      @(posedge clock);
      abort[0] <= 1'b0;
      wait_idle(0);
      $display("test pairing done");
      // zero count means a full 64K block; the core parks it after one burst
      start(2, mk(16'h0000, 2'h3, 16'h2000, 16'h4000));
      fire(2, TS_SW);
      core_access <= 1'b1;
      repeat (40) @(posedge clock);
      check(n_wr - w0, 8);
      check(busy[2], 1'b1);
      abort[2] <= 1'b1;
      @(posedge clock);
      abort[2] <= 1'b0;
      core_access <= 1'b0;
      wait_idle(2);
      check(n_err[2] - e0, 1);
      check(n_wr - w0, 8);
      $display("test abort done");
      close_out();
   end
endmodule // tb_top
